/* hdl/afm_pkg.sv */
// Constants, types and register map of the all-frame mode counter.
// Assumes one 40 MHz clock domain with synchronous active-high reset.
//
// Overview of operation
// [R1] Vector type 000 secure, 101 alphanumeric, 110 hex/binary qualify for counting.
// [R2] Each qualifying vector adds one to the counter and starts all-frame decoding; once the counter is at its top, the code adds nothing.
// [R3] In all-frame mode, forward frame information, then a status packet with EOF set.
// [R4] Each mode write with the decrement bit set takes one from the counter.
// [R5] Leave all-frame mode when count is zero, no temp address, force bit clear.
// [R6] Host does not decrement while a fragment shows the continued flag set.
// [R7] Host writes one decrement for a message whose continued flag is clear.
// [R8] Host decrements after later continued fragments, or once per fragment at message end.
// [R9] On the final fragment the host writes two decrements, first and last fragment.
// [R10] Host tracks outstanding fragmented messages and decrements for each of them.
// [R11] Host treats a gap over thirty-two or 128 frames as a broken message.
// [R12] Host uses checksum, fragment number 0 to 2 and message number per fragment.
// [R13] Host buffer holds 252 characters, three per word over eighty-four words.
// [R14] The end-of-frame status packet also carries the current frame number.
// [R15] Host may set decrement and temp-address disable bits in one mode write.
// [R16] A decrement at zero leaves the counter at zero without wrapping.
// [R17] The counter is wide enough for several outstanding fragmented messages.
package afm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W_DEF = 4;
  localparam int FRAME_W = 7;
  localparam int LINK_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  // Mode register fields
  localparam int BIT_DEC_ALL = 0;
  localparam int BIT_FORCE_ALL = 1;
  localparam int BIT_TEMP_DIS = 2;
  // Status register fields
  localparam int BIT_ACTIVE = 8;
  localparam int BIT_STAT_FORCE = 9;
  // Interrupt bits
  localparam int IRQ_N = 3;
  localparam int IRQ_EOF = 0;
  localparam int IRQ_EXIT = 1;
  localparam int IRQ_VEC = 2;
  localparam logic [IRQ_N-1:0] IRQ_RST = 3'h0;
  // Vector type codes
  localparam logic [2:0] VT_SECURE = 3'h0;
  localparam logic [2:0] VT_ALPHA = 3'h5;
  localparam logic [2:0] VT_HEXBIN = 3'h6;
  // Link word kinds
  localparam logic KIND_EOF = 1'b0;
  localparam logic KIND_VECTOR = 1'b1;
  localparam logic [LINK_W-1:0] LINK_RST = 8'h00;

  typedef struct packed {
    logic kind;
    logic [FRAME_W-1:0] payload;
  } link_word_t;

  typedef struct packed {
    logic eof;
    logic [FRAME_W-1:0] frame_num;
  } status_pkt_t;
endpackage

/* hdl/all_frame_mode_counter.sv */
// All-frame mode counter: takes vector and frame-end events from a serial link,
// counts outstanding fragmented messages and emits end-of-frame status packets.
// Assumes link pins are asynchronous to clk and toggle far slower than clk.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module all_frame_mode_counter #(
  parameter int CNT_W = afm_pkg::CNT_W_DEF
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [afm_pkg::ADDR_W-1:0] addr, // Register byte address
  input wire logic [afm_pkg::DATA_W-1:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [afm_pkg::DATA_W-1:0] rdata, // Read data, cycle after rd
  input wire logic link_clk, // Link bit clock pin
  input wire logic link_frame, // Link word enable pin
  input wire logic link_data, // Link serial data pin, MSB first
  input wire logic temp_pending, // A temporary address is outstanding
  output logic temp_disable, // Pulse: host asked to disable a temp address
  output logic all_frame, // High while every frame is decoded
  output logic vec_valid, // Pulse: vector forwarded to host path
  output logic [2:0] vector_type_field, // Type of forwarded vector
  output logic pkt_valid, // Pulse: status packet ready
  output afm_pkg::status_pkt_t pkt, // Status packet contents
  output logic irq // Level interrupt
);
  import afm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Link pin synchronisers
  // The third stage only feeds the edge detectors; no logic reads the first stage,
  // which may still be settling from a metastable sample
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= {link_clk, link_frame, link_data};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  wire lclk_rise = sync2_reg[2] & ~sync3_reg[2];
  wire lframe_on = sync2_reg[1];
  wire lframe_fall = ~sync2_reg[1] & sync3_reg[1];
  wire ldata = sync2_reg[0];

  //////////////////////////////////////////////////////////////////////////////
  // Link word assembly
  logic [LINK_W-1:0] shift_reg;
  logic [LINK_W-1:0] shift_next;
  logic [3:0] nbits_reg;
  logic [3:0] nbits_next;
  always_comb begin
    shift_next = shift_reg;
    nbits_next = nbits_reg;
    if (!lframe_on) begin
      nbits_next = 4'h0;
    end else if (lclk_rise) begin
      shift_next = {shift_reg[LINK_W-2:0], ldata};
      if (nbits_reg != 4'hf) begin
        nbits_next = nbits_reg + 4'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= LINK_RST;
      nbits_reg <= 4'h0;
    end else begin
      shift_reg <= shift_next;
      nbits_reg <= nbits_next;
    end
  end
  // A word with the wrong bit count is dropped rather than half decoded
  // The bit count stops at 15 so an over-long word never wraps back to a good count
  wire word_ok = lframe_fall & (nbits_reg == 4'(LINK_W));
  link_word_t word;
  assign word = shift_reg;
  wire is_vector = word_ok & (word.kind == KIND_VECTOR);
  wire is_eof = word_ok & (word.kind == KIND_EOF);
  wire [2:0] vtype = word.payload[2:0];

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_mode = wr & (addr == OFS_MODE);
  wire wr_clr = wr & (addr == OFS_IRQ_CLR);
  wire wr_en = wr & (addr == OFS_IRQ_EN);
  wire dec_req = wr_mode & wdata[BIT_DEC_ALL];
  // [R1] Vector type classification
  wire qualify = (vtype == VT_SECURE) | (vtype == VT_ALPHA) | (vtype == VT_HEXBIN);
  wire inc_req = is_vector & qualify;

  //////////////////////////////////////////////////////////////////////////////
  // All-frame counter
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic force_reg;
  wire cnt_max = &cnt_reg;
  wire cnt_zero = (cnt_reg == '0);
  // [R17] Saturate at the top so a burst cannot wrap to zero
  // A message beyond the top is then not counted: size CNT_W for the worst case
  wire do_inc = inc_req & ~cnt_max;
  // [R16] No decrement below zero
  wire do_dec = dec_req & ~cnt_zero;
  always_comb begin
    cnt_next = cnt_reg;
    // [R2] Count up on a qualifying vector
    if (do_inc & ~do_dec) begin
      cnt_next = cnt_reg + 1'b1;
    // [R4] Count down on a decrement write
    end else if (do_dec & ~do_inc) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      force_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (wr_mode) begin
        force_reg <= wdata[BIT_FORCE_ALL];
      end
    end
  end
  // [R5] Normal decoding only with nothing outstanding
  wire active_next = (cnt_next != '0) | force_reg | temp_pending;
  logic active_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end
  assign all_frame = active_reg;
  // [R15] Decrement and temp disable may share one write
  assign temp_disable = wr_mode & wdata[BIT_TEMP_DIS];

  //////////////////////////////////////////////////////////////////////////////
  // Forwarding and status packets
  logic vec_valid_reg;
  logic [2:0] vtype_reg;
  logic pkt_valid_reg;
  status_pkt_t pkt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_valid_reg <= 1'b0;
      vtype_reg <= 3'h0;
      pkt_valid_reg <= 1'b0;
      pkt_reg <= '0;
    end else begin
      vec_valid_reg <= is_vector;
      if (is_vector) begin
        vtype_reg <= vtype;
      end
      // [R3] End-of-frame packet while in all-frame mode
      pkt_valid_reg <= is_eof & active_reg;
      if (is_eof & active_reg) begin
        pkt_reg.eof <= 1'b1;
        // [R14] Carry the current frame number
        pkt_reg.frame_num <= word.payload;
      end
    end
  end
  assign vec_valid = vec_valid_reg;
  assign vector_type_field = vtype_reg;
  assign pkt_valid = pkt_valid_reg;
  assign pkt = pkt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [IRQ_N-1:0] ist_reg;
  logic [IRQ_N-1:0] ien_reg;
  wire [IRQ_N-1:0] ev;
  assign ev[IRQ_EOF] = pkt_valid_reg;
  assign ev[IRQ_EXIT] = active_reg & ~active_next;
  assign ev[IRQ_VEC] = inc_req;
  wire [IRQ_N-1:0] clr_bits = wr_clr ? wdata[IRQ_N-1:0] : '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      ist_reg <= IRQ_RST;
      ien_reg <= IRQ_RST;
    end else begin
      // Set beats clear so no event is lost
      ist_reg <= (ist_reg & ~clr_bits) | ev;
      if (wr_en) begin
        ien_reg <= wdata[IRQ_N-1:0];
      end
    end
  end
  assign irq = |(ist_reg & ien_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Read path
  // Field positions come from the package so the map has one owner
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] mode_word;
  always_comb begin
    stat_word = '0;
    stat_word[CNT_W-1:0] = cnt_reg;
    stat_word[BIT_ACTIVE] = active_reg;
    stat_word[BIT_STAT_FORCE] = force_reg;
    mode_word = '0;
    mode_word[BIT_FORCE_ALL] = force_reg;
  end
  // Unmapped and write-only offsets read as zero
  wire [DATA_W-1:0] rd_mux =
    (addr == OFS_MODE) ? mode_word :
    (addr == OFS_STATUS) ? stat_word :
    (addr == OFS_IRQ_STAT) ? {29'h0, ist_reg} :
    (addr == OFS_IRQ_EN) ? {29'h0, ien_reg} : 32'h0;
  logic [DATA_W-1:0] rdata_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rd ? rd_mux : 32'h0;
    end
  end
  assign rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_qual_inc: assert property (@(posedge clk) disable iff (rst) // [R2]
    (is_vector && qualify && !dec_req && !cnt_max) |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("qualifying vector did not increment");
  a_nonqual_hold: assert property (@(posedge clk) disable iff (rst) // [R1]
    (is_vector && !qualify && !dec_req) |=> $stable(cnt_reg))
    else $error("non-qualifying vector changed counter");
  a_dec_one: assert property (@(posedge clk) disable iff (rst) // [R4]
    (dec_req && !inc_req && !cnt_zero) |=> cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("decrement write did not decrement");
  a_zero_hold: assert property (@(posedge clk) disable iff (rst) // [R16]
    (dec_req && !inc_req && cnt_zero) |=> cnt_zero)
    else $error("counter wrapped below zero");
  a_max_hold: assert property (@(posedge clk) disable iff (rst) // [R17]
    (cnt_max && !dec_req) |=> cnt_max)
    else $error("counter wrapped above maximum");
  a_normal_exit: assert property (@(posedge clk) disable iff (rst) // [R5]
    (cnt_next == '0 && !force_reg && !temp_pending) |=> !all_frame)
    else $error("stayed in all-frame mode with nothing pending");
  a_active_cnt: assert property (@(posedge clk) disable iff (rst) // [R2]
    (!cnt_zero) |-> all_frame)
    else $error("counter nonzero but not in all-frame mode");
  a_eof_pkt: assert property (@(posedge clk) disable iff (rst) // [R3]
    (is_eof && active_reg) |=> pkt_valid && pkt.eof)
    else $error("missing end-of-frame packet");
  a_eof_frame: assert property (@(posedge clk) disable iff (rst) // [R14]
    (is_eof && active_reg) |=> pkt.frame_num == $past(word.payload))
    else $error("wrong frame number in status packet");
  a_no_pkt_idle: assert property (@(posedge clk) disable iff (rst) // [R3]
    pkt_valid |-> $past(is_eof) && $past(active_reg))
    else $error("status packet outside all-frame mode");
  a_dta_pass: assert property (@(posedge clk) disable iff (rst) // [R15]
    (wr_mode && wdata[BIT_TEMP_DIS] && wdata[BIT_DEC_ALL]) |-> temp_disable && dec_req)
    else $error("combined write lost a bit");

  // Counter moves only on a request, and a clash of both leaves it alone unless the counter is at zero or at its top
  a_cancel_hold: assert property (@(posedge clk) disable iff (rst) // [R4]
    (do_inc && do_dec) |=> $stable(cnt_reg))
    else $error("simultaneous increment and decrement moved counter");
  a_no_req_hold: assert property (@(posedge clk) disable iff (rst) // [R4]
    (!inc_req && !dec_req) |=> $stable(cnt_reg))
    else $error("counter moved without a request");

  // Mode entry and exit
  a_inc_enters: assert property (@(posedge clk) disable iff (rst) // [R2]
    (inc_req && !dec_req) |=> all_frame)
    else $error("qualifying vector did not enter all-frame mode");
  a_force_keeps: assert property (@(posedge clk) disable iff (rst) // [R5]
    force_reg |=> all_frame)
    else $error("force bit set but all-frame mode left");
  a_temp_keeps: assert property (@(posedge clk) disable iff (rst) // [R5]
    temp_pending |=> all_frame)
    else $error("temporary address pending but all-frame mode left");
  a_exit_zero: assert property (@(posedge clk) disable iff (rst) // [R5]
    $fell(all_frame) |-> cnt_zero)
    else $error("left all-frame mode with counter nonzero");
  a_exit_flag: assert property (@(posedge clk) disable iff (rst) // [R5]
    (all_frame && !active_next) |=> ist_reg[IRQ_EXIT])
    else $error("mode exit not flagged");

  // Forwarding and status flags
  a_vec_fwd: assert property (@(posedge clk) disable iff (rst) // [R1]
    is_vector |=> vec_valid && vector_type_field == $past(vtype))
    else $error("vector not forwarded with its type");
  a_type_hold: assert property (@(posedge clk) disable iff (rst) // [R1]
    !is_vector |=> $stable(vector_type_field))
    else $error("vector type changed without a vector");
  a_vec_flag: assert property (@(posedge clk) disable iff (rst) // [R2]
    inc_req |=> ist_reg[IRQ_VEC])
    else $error("qualifying vector not flagged");
  a_pkt_eof: assert property (@(posedge clk) disable iff (rst) // [R3]
    pkt_valid |-> pkt.eof)
    else $error("status packet without end-of-frame flag");
  a_eof_flag: assert property (@(posedge clk) disable iff (rst) // [R3]
    pkt_valid |=> ist_reg[IRQ_EOF])
    else $error("status packet not flagged");
endmodule

/* test/link_sender.sv */
// Far-side model: shifts 8-bit link words into the counter, MSB first.
// Assumes the receiver samples link_data on each link_clk rise while link_frame is high.
`timescale 1ns/1ps
module link_sender (
  output logic link_clk, // Link bit clock, still outside words
  output logic link_frame, // High while a word is shifted
  output logic link_data // Serial data
);
  initial begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_data = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // 200 ns bit period; data is inverted after the word so a stale bit never looks valid
  task automatic send(input logic [7:0] w);
    link_frame = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      link_data = w[i];
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    #100 link_frame = 1'b0;
    link_data = ~w[0];
    #200;
  endtask
endmodule

/* test/test_all_frame_mode_counter.sv */
// Self-checking bench for the all-frame mode counter.
// Assumes the register map and link word format of afm_pkg.
`timescale 1ns/1ps
module test_all_frame_mode_counter;
  import afm_pkg::*;
  logic clk, rst, wr, rd, temp_pending, temp_disable, all_frame, vec_valid, pkt_valid, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] vector_type_field;
  logic link_clk, link_frame, link_data;
  status_pkt_t pkt, last_pkt;
  int n_errors = 0;
  int num_checks = 0;
  int n_ev = 0;
  int ev_base = 0;
  logic [3:0] row_cnt [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3};

  all_frame_mode_counter #(.CNT_W(4)) dut_u (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_clk(link_clk),
    .link_frame(link_frame), .link_data(link_data), .temp_pending(temp_pending),
    .temp_disable(temp_disable), .all_frame(all_frame), .vec_valid(vec_valid),
    .vector_type_field(vector_type_field), .pkt_valid(pkt_valid), .pkt(pkt), .irq(irq));
  link_sender link_u (.link_clk(link_clk), .link_frame(link_frame), .link_data(link_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (vec_valid === 1'b1 || pkt_valid === 1'b1) n_ev++;
    if (pkt_valid === 1'b1) last_pkt = pkt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // A word must produce a vector or packet event within a bounded wait
  task automatic send_word(input logic [7:0] w);
    int seen;
    seen = n_ev;
    link_u.send(w);
    for (int i = 0; i < 40 && n_ev == seen; i++) @(posedge clk);
    if (n_ev == seen) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, 0, 1);
      report_and_stop();
    end
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    temp_pending = 1'b0;
    last_pkt = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int r = 0; r < 8; r++) begin
      send_word({5'h10, r[2:0]});
      chk({29'h0, vector_type_field}, r);
      rd_chk(OFS_STATUS, {23'h0, 1'b1, 4'h0, row_cnt[r]});
    end
    $display("vector type table done");
    repeat (4) wr_reg(OFS_MODE, 32'h1);
    rd_chk(OFS_STATUS, 32'h0);
    chk({31'h0, all_frame}, 32'h0);
    wr_reg(OFS_IRQ_CLR, 32'h7);
    $display("decrement at zero done");
    wr_reg(OFS_IRQ_EN, 32'h2);
    // Three fragments one frame apart, each within one frame's 252 characters
    send_word({1'b1, 4'h0, VT_ALPHA});
    send_word(8'h05);
    chk({24'h0, last_pkt}, 32'h85);
    send_word({1'b1, 4'h0, VT_ALPHA});
    // Later continued fragment: one decrement
    wr_reg(OFS_MODE, 32'h1);
    rd_chk(OFS_STATUS, 32'h101);
    send_word(8'h06);
    chk({24'h0, last_pkt}, 32'h86);
    send_word({1'b1, 4'h0, VT_HEXBIN});
    chk({31'h0, irq}, 32'h0);
    // Final fragment: two decrements
    wr_reg(OFS_MODE, 32'h1);
    wr_reg(OFS_MODE, 32'h1);
    rd_chk(OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd_chk(OFS_IRQ_STAT, 32'h7);
    wr_reg(OFS_IRQ_CLR, 32'h7);
    #1 chk({31'h0, irq}, 32'h0);
    $display("fragmented message done");
    wr_reg(OFS_MODE, 32'h2);
    rd_chk(OFS_STATUS, 32'h300);
    wr_reg(OFS_MODE, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    temp_pending <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, all_frame}, 32'h1);
    temp_pending <= 1'b0;
    send_word({1'b1, 4'h0, VT_SECURE});
    @(posedge clk);
    addr <= OFS_MODE;
    wdata <= 32'h5;
    wr <= 1'b1;
    #1 chk({31'h0, temp_disable}, 32'h1);
    @(posedge clk);
    wr <= 1'b0;
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(8'h14, 32'h0);
    rd_chk(OFS_IRQ_CLR, 32'h0);
    $display("force, temp and map done");
    // Fill the counter past its top, then drain it one write at a time
    for (int i = 0; i < 16; i++) begin
      send_word({1'b1, 4'h0, VT_HEXBIN});
    end
    rd_chk(OFS_STATUS, 32'h10f);
    repeat (15) wr_reg(OFS_MODE, 32'h1);
    rd_chk(OFS_STATUS, 32'h0);
    // Outside all-frame mode a frame end gives no status packet
    ev_base = n_ev;
    link_u.send(8'h07);
    repeat (8) @(posedge clk);
    chk(n_ev, ev_base);
    $display("saturation and idle frame end done");
    send_word({1'b1, 4'h0, VT_ALPHA});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({31'h0, all_frame}, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    $display("reset test done");
    report_and_stop();
  end
endmodule
